// ---- inc/fifo_map.svh ----
// Constants of the 16x5 strobed first-in first-out buffer
`ifndef FIFO_MAP_SVH
`define FIFO_MAP_SVH
`define FIFO_DEPTH        16
`define FIFO_WIDTH        5
`define FIFO_ALMOST_FULL  15
`define FIFO_ALMOST_EMPTY 2
`define FIFO_SYNC_STAGES  3
`define INT_STATUS_ADDR   12'h000
`define INT_MASK_ADDR     12'h004
`define FILL_LEVEL_ADDR   12'h008
`define INT_EV_FULL       0
`define INT_EV_EMPTY      1
`define INT_EV_OVERFLOW   2
`define INT_EV_UNDERFLOW  3
`define INT_EV_WIDTH      4
`define INT_MASK_RESET    4'h0
`endif

// ---- inc/fifo_pkg.sv ----
// Types of the 16x5 strobed first-in first-out buffer
package fifo_pkg;
    typedef logic [3:0] fifo_ev_t;
endpackage

// ---- src/fifo_edge_sync.sv ----
// Three-stage synchroniser with rising-edge detection for one strobe pin
`timescale 1ns/1ps
module fifo_edge_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin side
    input  wire logic pin,
    // Clock domain side
    output logic      rise
);
    logic       meta_ff;
    logic       nxt_meta;
    logic [1:0] pair_ff;
    logic [1:0] nxt_pair;
    logic       level_ff;
    logic       nxt_level;

    always_comb begin
        nxt_meta  = pin;
        nxt_pair  = {pair_ff[0], meta_ff};
        nxt_level = level_ff;
        // A change counts only once stages two and three agree
        if (pair_ff[0] == pair_ff[1]) begin
            nxt_level = pair_ff[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff  <= 1'b0;
            pair_ff  <= 2'h0;
            level_ff <= 1'b0;
        end else begin
            meta_ff  <= nxt_meta;
            pair_ff  <= nxt_pair;
            level_ff <= nxt_level;
        end
    end

    assign rise = nxt_level & ~level_ff;
endmodule

// ---- src/fifo_16x5.sv ----
// Sixteen by five strobed first-in first-out buffer with flags and APB status
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "fifo_map.svh"
module fifo_16x5 #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int WIDTH = `FIFO_WIDTH
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Write side
    input  wire logic              load_strobe,
    input  wire logic [WIDTH-1:0]  data_in,
    // Read side
    input  wire logic              unload_strobe,
    input  wire logic              out_enable,
    output logic      [WIDTH-1:0]  data_out,
    output logic      [WIDTH-1:0]  data_out_oe,
    // Status flags, active low
    output logic                   full_n,
    output logic                   almost_full_n,
    output logic                   empty_n,
    output logic                   almost_empty_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Interrupt
    output logic                   irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] CNT_FULL   = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_AFULL  = CW'(`FIFO_ALMOST_FULL);
    localparam logic [CW-1:0] CNT_AEMPTY = CW'(`FIFO_ALMOST_EMPTY);

    logic             load_rise;
    logic             unload_rise;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    nxt_wr_ptr;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW-1:0]    nxt_rd_ptr;
    logic [CW-1:0]    word_count_ff;
    logic [CW-1:0]    nxt_word_count;
    logic [WIDTH-1:0] head_ff;
    logic [WIDTH-1:0] nxt_head;
    logic             wr_ok;
    logic             rd_ok;
    logic             is_full;
    logic             is_empty;

    fifo_edge_sync u_load_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (load_strobe),
        .rise    (load_rise)
    );

    fifo_edge_sync u_unload_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (unload_strobe),
        .rise    (unload_rise)
    );

    assign is_full  = (word_count_ff == CNT_FULL);
    assign is_empty = (word_count_ff == '0);
    assign wr_ok    = load_rise & ~is_full;
    assign rd_ok    = unload_rise & ~is_empty;

    // Storage, one generate entry per word
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
        always_comb begin
            nxt_mem[i] = mem_ff[i];
            if (wr_ok && (wr_ptr_ff == PW'(i))) begin
                nxt_mem[i] = data_in;
            end
        end
        // Storage has no reset, like the array it models
        always_ff @(posedge pclk) begin
            mem_ff[i] <= nxt_mem[i];
        end
    end

    always_comb begin
        nxt_wr_ptr     = wr_ptr_ff;
        nxt_rd_ptr     = rd_ptr_ff;
        nxt_word_count = word_count_ff;
        if (wr_ok) begin
            nxt_wr_ptr = wr_ptr_ff + PW'(1);
        end
        if (rd_ok) begin
            nxt_rd_ptr = rd_ptr_ff + PW'(1);
        end
        if (wr_ok && !rd_ok) begin
            nxt_word_count = word_count_ff + CW'(1);
        end else if (rd_ok && !wr_ok) begin
            nxt_word_count = word_count_ff - CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff     <= '0;
            rd_ptr_ff     <= '0;
            word_count_ff <= '0;
        end else begin
            wr_ptr_ff     <= nxt_wr_ptr;
            rd_ptr_ff     <= nxt_rd_ptr;
            word_count_ff <= nxt_word_count;
        end
    end

    // Fall-through head: a write into an empty buffer (or one being drained to empty) goes straight out
    always_comb begin
        nxt_head = head_ff;
        if (wr_ok && (is_empty || (rd_ok && word_count_ff == CW'(1)))) begin
            nxt_head = data_in;
        end else if (rd_ok) begin
            nxt_head = mem_ff[rd_ptr_ff + PW'(1)];
        end else if (wr_ok && word_count_ff == '0) begin
            nxt_head = data_in;
        end
    end

    // Not reset: head keeps its value through reset
    always_ff @(posedge pclk) begin
        head_ff <= nxt_head;
    end

    assign data_out    = head_ff;
    assign data_out_oe = {WIDTH{out_enable}};

    // Flags come from count only, out_enable never enters them
    logic flags_ff;
    logic [3:0] flag_ff;
    logic [3:0] nxt_flag;
    always_comb begin
        nxt_flag[0] = ~(nxt_word_count == CNT_FULL);
        nxt_flag[1] = ~(nxt_word_count == CNT_AFULL);
        nxt_flag[2] = ~(nxt_word_count == '0);
        nxt_flag[3] = ~(nxt_word_count == CNT_AEMPTY);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff  <= 4'hB;
            flags_ff <= 1'b0;
        end else begin
            flag_ff  <= nxt_flag;
            flags_ff <= 1'b1;
        end
    end
    assign full_n         = flag_ff[0];
    assign almost_full_n  = flag_ff[1];
    assign empty_n        = flag_ff[2];
    assign almost_empty_n = flag_ff[3];

    // APB status, mask and fill level
    fifo_pkg::fifo_ev_t status_ff;
    fifo_pkg::fifo_ev_t nxt_status;
    fifo_pkg::fifo_ev_t mask_ff;
    fifo_pkg::fifo_ev_t nxt_mask;
    fifo_pkg::fifo_ev_t events;
    logic [31:0]        nxt_prdata;
    logic [31:0]        prdata_ff;
    logic               wr_acc;
    logic               rd_acc;
    logic               hit;

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;
    assign hit    = (paddr == `INT_STATUS_ADDR) || (paddr == `INT_MASK_ADDR) || (paddr == `FILL_LEVEL_ADDR);

    always_comb begin
        events = '0;
        events[`INT_EV_FULL]      = wr_ok && (word_count_ff == CNT_FULL - CW'(1)) && !rd_ok;
        events[`INT_EV_EMPTY]     = rd_ok && (word_count_ff == CW'(1)) && !wr_ok;
        events[`INT_EV_OVERFLOW]  = load_rise & is_full;
        events[`INT_EV_UNDERFLOW] = unload_rise & is_empty;
        nxt_status = status_ff;
        nxt_mask   = mask_ff;
        if (wr_acc && paddr == `INT_STATUS_ADDR) begin
            nxt_status = status_ff & ~pwdata[`INT_EV_WIDTH-1:0];
        end
        if (wr_acc && paddr == `INT_MASK_ADDR) begin
            nxt_mask = pwdata[`INT_EV_WIDTH-1:0];
        end
        // Set wins over a clear in the same cycle
        nxt_status = nxt_status | events;
        nxt_prdata = prdata_ff;
        if (rd_acc) begin
            nxt_prdata = '0;
            case (paddr)
                `INT_STATUS_ADDR: nxt_prdata[`INT_EV_WIDTH-1:0] = status_ff;
                `INT_MASK_ADDR:   nxt_prdata[`INT_EV_WIDTH-1:0] = mask_ff;
                `FILL_LEVEL_ADDR: nxt_prdata[CW-1:0] = word_count_ff;
                default:          nxt_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= '0;
            mask_ff   <= `INT_MASK_RESET;
            prdata_ff <= '0;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign irq     = |(status_ff & mask_ff);

    // Checks
    // Flags are registered from the next count, so they line up with the count register
    full_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        flags_ff |-> (full_n == (word_count_ff != CNT_FULL))
    ) else $error("full flag wrong");

    full_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (word_count_ff == CNT_FULL) |-> !full_n
    ) else $error("full flag not low at sixteen");

    afull_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (almost_full_n == (word_count_ff != CNT_AFULL))
    ) else $error("almost full flag wrong");

    empty_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (empty_n == (word_count_ff != '0))
    ) else $error("empty flag wrong");

    aempty_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (almost_empty_n == (word_count_ff != CNT_AEMPTY))
    ) else $error("almost empty flag wrong");

    no_overfill_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_full && load_rise && !unload_rise |=> (word_count_ff == CNT_FULL) && $stable(wr_ptr_ff)
    ) else $error("write accepted while full");

    no_underread_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_empty && unload_rise |=> $stable(rd_ptr_ff)
    ) else $error("read advanced while empty");

    count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok && !rd_ok |=> word_count_ff == $past(word_count_ff) + CW'(1)
    ) else $error("count did not rise");

    fall_through_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_empty && wr_ok |=> (data_out == $past(data_in)) && empty_n
    ) else $error("first word not presented");

    oe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_out_oe == {WIDTH{out_enable}}
    ) else $error("output enable wrong");

    count_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_ok && !wr_ok |=> word_count_ff == $past(word_count_ff) - CW'(1)
    ) else $error("count did not fall");

    count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_ok && wr_ok |=> $stable(word_count_ff)
    ) else $error("count moved on a paired write and read");

    // Toggling the drivers alone must never disturb a flag
    oe_no_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(out_enable) && !load_rise && !unload_rise |=> $stable({full_n, almost_full_n, empty_n, almost_empty_n})
    ) else $error("flags moved with output enable");

    // The reader may leave the head word in place while writes go on behind it
    head_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !is_empty && !rd_ok |=> $stable(data_out)
    ) else $error("head word changed without an unload");

    full_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_full && !unload_rise |=> is_full
    ) else $error("full buffer left full without an unload");

    empty_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_empty && !load_rise |=> is_empty
    ) else $error("empty buffer filled without a load");

    count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        word_count_ff <= CNT_FULL
    ) else $error("count above depth");

    // Pointer distance and count are kept separately; they must never drift apart
    ptr_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ptr_ff - rd_ptr_ff) == word_count_ff[PW-1:0]
    ) else $error("pointer distance differs from count");

    // A sticky event must be visible the cycle after it fires, even under a clear
    status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        events != '0 |=> (status_ff & $past(events)) == $past(events)
    ) else $error("status event lost");

    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready
    ) else $error("access phase not answered");
endmodule

// ---- testbench/afb_peer.sv ----
// Writing and reading systems that pulse the two strobes on request
`timescale 1ns/1ps
module afb_peer (
    // Clock
    input  wire logic       pclk,
    // Requests from the bench
    input  wire logic       push,
    input  wire logic [4:0] word,
    input  wire logic       pull,
    // Pins toward the buffer, and busy back to the bench
    output logic            load_strobe = 1'b0,
    output logic      [4:0] data_in = 5'h0A,
    output logic            unload_strobe = 1'b0,
    output logic            busy
);
    logic [3:0] wcnt = 4'h0;
    logic [3:0] rcnt = 4'h0;
    assign busy = (wcnt != 4'h0) || (rcnt != 4'h0);
    // Strobes high four cycles, low at least four; two sides run independently
    always @(posedge pclk) begin
        if (push && wcnt == 4'h0) begin
            wcnt        <= 4'hC;
            data_in     <= word;
            load_strobe <= 1'b1;
        end else if (wcnt != 4'h0) begin
            wcnt <= wcnt - 4'h1;
            if (wcnt == 4'h9) load_strobe <= 1'b0;
            // Hold time over: data lines no longer show the stored word
            if (wcnt == 4'h3) data_in <= ~data_in;
        end
        if (pull && rcnt == 4'h0) begin
            rcnt          <= 4'hC;
            unload_strobe <= 1'b1;
        end else if (rcnt != 4'h0) begin
            rcnt <= rcnt - 4'h1;
            if (rcnt == 4'h9) unload_strobe <= 1'b0;
        end
    end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the strobed buffer and its APB status block
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, push, pull, out_enable, psel, penable, pwrite, pready, pslverr, irq;
    logic ld, ul, busy, full_n, almost_full_n, empty_n, almost_empty_n;
    logic [4:0]  word, din, data_out, data_out_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    int error_cnt = 0;
    int n_tests = 0;
    afb_peer PEER (.pclk(pclk), .push(push), .word(word), .pull(pull), .load_strobe(ld),
        .data_in(din), .unload_strobe(ul), .busy(busy));
    fifo_16x5 DUT (.pclk(pclk), .presetn(presetn), .load_strobe(ld), .data_in(din),
        .unload_strobe(ul), .out_enable(out_enable), .data_out(data_out), .data_out_oe(data_out_oe),
        .full_n(full_n), .almost_full_n(almost_full_n), .empty_n(empty_n), .almost_empty_n(almost_empty_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic flags(input int n);
        chk({full_n, almost_full_n, empty_n, almost_empty_n}, {n != 16, n != 15, n != 0, n != 2});
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            error_cnt++;
            give_verdict();
        end
        r = wr ? {31'h0, pslverr} : (pslverr === 1'b1 ? 32'hFFFFFFFF : prdata);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic op(input logic p, input logic u, input logic [4:0] w);
        int i;
        @(posedge pclk);
        push <= p; pull <= u; word <= w;
        @(posedge pclk);
        push <= 1'b0; pull <= 1'b0;
        // Busy rises only at this edge; sample it one edge later to avoid racing the peer
        @(posedge pclk);
        for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge pclk);
        if (i == 40) begin
            error_cnt++;
            give_verdict();
        end
        @(posedge pclk);
    endtask
    function automatic logic [4:0] wd(input int i);
        return 5'(i * 7 + 3);
    endfunction
    initial begin
        presetn = 1'b0; push = 1'b0; pull = 1'b0; word = 5'h00; out_enable = 1'b1;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        flags(0);
        apb(1'b0, 12'h008, 0, rv); chk(rv, 0);
        apb(1'b0, 12'h004, 0, rv); chk(rv, 0);
        apb(1'b0, 12'h010, 0, rv); chk(rv, 32'hFFFFFFFF);
        apb(1'b1, 12'h000, 32'hF, rv);
        for (int i = 0; i < 16; i++) begin
            op(1'b1, 1'b0, wd(i));
            flags(i + 1);
            apb(1'b0, 12'h008, 0, rv); chk(rv, i + 1);
            chk(data_out, wd(0));
        end
        op(1'b1, 1'b0, 5'h1F);
        flags(16);
        apb(1'b0, 12'h000, 0, rv); chk(rv & 32'h5, 32'h5);
        apb(1'b1, 12'h004, 32'h4, rv);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, 12'h000, 32'h4, rv);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        out_enable <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(data_out_oe, 5'h00);
        flags(16);
        out_enable <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(data_out_oe, 5'h1F);
        for (int i = 0; i < 16; i++) begin
            chk(data_out, wd(i));
            op(1'b0, 1'b1, 5'h00);
            flags(15 - i);
        end
        op(1'b0, 1'b1, 5'h00);
        flags(0);
        apb(1'b0, 12'h008, 0, rv); chk(rv, 0);
        apb(1'b0, 12'h000, 0, rv); chk(rv & 32'h8, 32'h8);
        op(1'b1, 1'b0, 5'h0C);
        chk(data_out, 5'h0C);
        op(1'b1, 1'b1, 5'h0D);
        apb(1'b0, 12'h008, 0, rv); chk(rv, 1);
        chk(data_out, 5'h0D);
        // Reset in mid-run must leave the output word alone
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        flags(0);
        chk(data_out, 5'h0D);
        give_verdict();
    end
endmodule
